/* lpr_params.svh */
// How it works
// RQ1 - Control bits 7:6 pick LED drive current.
// RQ2 - Control bits 5:4 pick proximity photodiode.
// RQ3 - Host writes zeros into control bits 3:2.
// RQ4 - Control bits 1:0 pick ambient light gain.
// RQ5 - Read-only identification register at 0x12.
// RQ6 - Read-only status at 0x13, writes ignored.
// RQ7 - Status bit 5 mirrors proximity interrupt.
// RQ8 - Status bit 4 mirrors light interrupt.
// RQ9 - Status bit 0 set after light integration.
// RQ10 - Two light results at 0x14 to 0x17.
// RQ11 - Low byte read latches that channel's high byte.
// RQ12 - Latched high byte survives new integrations.
// RQ13 - Host reads low byte then high byte.
// RQ14 - Proximity result at 0x18 and 0x19.
// RQ15 - Proximity low read latches its high byte.
// RQ16 - Interrupt pin is open drain, low active.
// RQ17 - Light interrupt judged on first channel only.
// RQ18 - Reserved status bits read as zero.
`ifndef LPR_PARAMS_SVH
`define LPR_PARAMS_SVH
`define LPR_ADDR_CTRL 8'h0F
`define LPR_ADDR_ID 8'h12
`define LPR_ADDR_STAT 8'h13
`define LPR_ADDR_L0_LO 8'h14
`define LPR_ADDR_L0_HI 8'h15
`define LPR_ADDR_L1_LO 8'h16
`define LPR_ADDR_L1_HI 8'h17
`define LPR_ADDR_PX_LO 8'h18
`define LPR_ADDR_PX_HI 8'h19
`define LPR_CTRL_RST 8'h10
`define LPR_CTRL_WMASK 8'hF3
`define LPR_DRV_HI 7
`define LPR_DRV_LO 6
`define LPR_DIODE_HI 5
`define LPR_DIODE_LO 4
`define LPR_GAIN_HI 1
`define LPR_GAIN_LO 0
`define LPR_ST_PIRQ 5
`define LPR_ST_AIRQ 4
`define LPR_ST_VALID 0
`define LPR_DIODE_RSVD 2'h0
`define LPR_ID_VALUE 8'h5A
`endif

/* lpr_pkg.sv */
package lpr_pkg;
    typedef enum logic [1:0] {
        LPR_DRV_100MA = 2'h0,
        LPR_DRV_50MA = 2'h1,
        LPR_DRV_25MA = 2'h2,
        LPR_DRV_12MA5 = 2'h3
    } lpr_drive_t;
    typedef enum logic [1:0] {
        LPR_DIODE_NONE = 2'h0,
        LPR_DIODE_FIRST = 2'h1,
        LPR_DIODE_SECOND = 2'h2,
        LPR_DIODE_BOTH = 2'h3
    } lpr_diode_t;
    typedef enum logic [1:0] {
        LPR_GAIN_1X = 2'h0,
        LPR_GAIN_8X = 2'h1,
        LPR_GAIN_16X = 2'h2,
        LPR_GAIN_120X = 2'h3
    } lpr_gain_t;
    typedef struct packed {
        logic [7:0] low_r;
        logic [7:0] shadow_r;
    } lpr_shadow_st_t;
    typedef struct packed {
        logic [7:0] ctrl_r;
        logic valid_r;
        logic [7:0] rdata_r;
    } lpr_top_st_t;
endpackage

/* lpr_shadow_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lpr_shadow_if;
    logic [15:0] result;
    logic capture;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    modport owner (input result, input capture, output low_byte, output high_byte);
    modport user (output result, output capture, input low_byte, input high_byte);
endinterface
`default_nettype wire

/* lpr_shadow.sv */
`timescale 1ns/1ps
`default_nettype none
module lpr_shadow (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Result and capture strobe.
    lpr_shadow_if.owner sh
);
    import lpr_pkg::*;
    lpr_shadow_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        // The high byte is frozen with the low byte so a pair always matches.
        if (sh.capture) begin
            st_nxt.low_r = sh.result[7:0]; // RQ11
            st_nxt.shadow_r = sh.result[15:8]; // RQ12
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sh.low_byte = sh.capture ? sh.result[7:0] : st_r.low_r;
    assign sh.high_byte = st_r.shadow_r;

    shadow_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !sh.capture |=> sh.high_byte == $past(sh.high_byte)) else $error("shadow changed without capture"); // RQ12
    shadow_take_a: assert property (@(posedge clk) disable iff (!nrst)
        sh.capture |=> sh.high_byte == $past(sh.result[15:8])) else $error("shadow missed capture"); // RQ11
endmodule
`default_nettype wire

/* light_prox_result_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpr_params.svh"
module light_prox_result_regs (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register access port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Measurement core.
    input wire logic light_cycle_done,
    input wire logic [15:0] light_first_result,
    input wire logic [15:0] light_second_result,
    input wire logic [15:0] prox_result,
    input wire logic prox_irq_flag,
    input wire logic light_irq_flag,
    input wire logic light_valid_clear,
    // Analog settings.
    output lpr_pkg::lpr_drive_t led_drive_level,
    output lpr_pkg::lpr_diode_t prox_diode_select,
    output lpr_pkg::lpr_gain_t light_gain_select,
    output logic light_irq_source_first,
    // Open-drain interrupt pin.
    output logic int_o,
    output logic int_oe_n
);
    import lpr_pkg::*;

    // ************************************************
    // Result shadows
    // ************************************************
    lpr_shadow_if sh_l0();
    lpr_shadow_if sh_l1();
    lpr_shadow_if sh_px();

    assign sh_l0.result = light_first_result; // RQ10
    assign sh_l1.result = light_second_result; // RQ10
    assign sh_px.result = prox_result; // RQ14
    assign sh_l0.capture = reg_rd && reg_addr == `LPR_ADDR_L0_LO; // RQ11
    assign sh_l1.capture = reg_rd && reg_addr == `LPR_ADDR_L1_LO; // RQ11
    assign sh_px.capture = reg_rd && reg_addr == `LPR_ADDR_PX_LO; // RQ15

    lpr_shadow u_l0 (.clk(clk), .nrst(nrst), .sh(sh_l0));
    lpr_shadow u_l1 (.clk(clk), .nrst(nrst), .sh(sh_l1));
    lpr_shadow u_px (.clk(clk), .nrst(nrst), .sh(sh_px));

    // ************************************************
    // Register state
    // ************************************************
    lpr_top_st_t st_r, st_nxt;
    logic [7:0] status;
    logic pirq_s1_r, pirq_s2_r, airq_s1_r, airq_s2_r;

    // Interrupt flags arrive from the analog side and are synchronised first.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pirq_s1_r <= 1'b0;
            pirq_s2_r <= 1'b0;
            airq_s1_r <= 1'b0;
            airq_s2_r <= 1'b0;
        end else begin
            pirq_s1_r <= prox_irq_flag;
            pirq_s2_r <= pirq_s1_r;
            airq_s1_r <= light_irq_flag;
            airq_s2_r <= airq_s1_r;
        end
    end

    always_comb begin
        status = 8'h00; // RQ18
        status[`LPR_ST_PIRQ] = pirq_s2_r; // RQ7
        status[`LPR_ST_AIRQ] = airq_s2_r; // RQ8
        status[`LPR_ST_VALID] = st_r.valid_r; // RQ9
    end

    always_comb begin
        st_nxt = st_r;
        // Control is the only writable register; ID and status ignore writes.
        if (reg_wr && reg_addr == `LPR_ADDR_CTRL) begin
            st_nxt.ctrl_r = reg_wdata & `LPR_CTRL_WMASK; // RQ3
        end
        // Completion wins over a clear in the same cycle.
        if (light_cycle_done) begin
            st_nxt.valid_r = 1'b1; // RQ9
        end else if (light_valid_clear) begin
            st_nxt.valid_r = 1'b0;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `LPR_ADDR_CTRL: begin
                    st_nxt.rdata_r = st_r.ctrl_r;
                end
                `LPR_ADDR_ID: begin
                    st_nxt.rdata_r = `LPR_ID_VALUE; // RQ5
                end
                `LPR_ADDR_STAT: begin
                    st_nxt.rdata_r = status; // RQ6
                end
                `LPR_ADDR_L0_LO: begin
                    st_nxt.rdata_r = sh_l0.low_byte;
                end
                `LPR_ADDR_L0_HI: begin
                    st_nxt.rdata_r = sh_l0.high_byte; // RQ11
                end
                `LPR_ADDR_L1_LO: begin
                    st_nxt.rdata_r = sh_l1.low_byte;
                end
                `LPR_ADDR_L1_HI: begin
                    st_nxt.rdata_r = sh_l1.high_byte; // RQ11
                end
                `LPR_ADDR_PX_LO: begin
                    st_nxt.rdata_r = sh_px.low_byte;
                end
                `LPR_ADDR_PX_HI: begin
                    st_nxt.rdata_r = sh_px.high_byte; // RQ15
                end
                default: begin
                    st_nxt.rdata_r = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r.ctrl_r <= `LPR_CTRL_RST;
            st_r.valid_r <= 1'b0;
            st_r.rdata_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign reg_rdata = st_r.rdata_r;
    assign led_drive_level = lpr_drive_t'(st_r.ctrl_r[`LPR_DRV_HI:`LPR_DRV_LO]); // RQ1
    assign prox_diode_select = lpr_diode_t'(st_r.ctrl_r[`LPR_DIODE_HI:`LPR_DIODE_LO]); // RQ2
    assign light_gain_select = lpr_gain_t'(st_r.ctrl_r[`LPR_GAIN_HI:`LPR_GAIN_LO]); // RQ4
    assign light_irq_source_first = 1'b1; // RQ17
    // The pin is only ever pulled low; the pull-up sets the idle level.
    assign int_o = 1'b0; // RQ16
    assign int_oe_n = !(pirq_s2_r || airq_s2_r); // RQ16

    // ************************************************
    // Checks
    // ************************************************
    ctrl_rsvd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == `LPR_ADDR_CTRL |=> st_r.ctrl_r[3:2] == 2'h0) else $error("reserved control bits kept"); // RQ3
    ctrl_write_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == `LPR_ADDR_CTRL |=> led_drive_level == $past(reg_wdata[7:6])
        && light_gain_select == $past(reg_wdata[1:0]) && prox_diode_select == $past(reg_wdata[5:4])) else $error("control field lost"); // RQ1
    id_read_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `LPR_ADDR_ID |=> reg_rdata == `LPR_ID_VALUE) else $error("id read wrong"); // RQ5
    stat_read_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `LPR_ADDR_STAT |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:1] == 3'h0
        && reg_rdata[5] == $past(pirq_s2_r) && reg_rdata[4] == $past(airq_s2_r)) else $error("status read wrong"); // RQ7
    valid_set_a: assert property (@(posedge clk) disable iff (!nrst)
        light_cycle_done |=> st_r.valid_r) else $error("valid not set"); // RQ9
    pair_read_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `LPR_ADDR_PX_LO ##1 reg_rd && reg_addr == `LPR_ADDR_PX_HI
        |=> reg_rdata == $past(prox_result[15:8], 2)) else $error("proximity pair torn"); // RQ15
    light_pair_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `LPR_ADDR_L0_LO ##1 reg_rd && reg_addr == `LPR_ADDR_L0_HI
        |=> reg_rdata == $past(light_first_result[15:8], 2)) else $error("light pair torn"); // RQ12
    irq_pin_a: assert property (@(posedge clk) disable iff (!nrst)
        int_oe_n == !(status[5] || status[4])) else $error("pin disagrees with status"); // RQ16
    cv_pair: cover property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `LPR_ADDR_L1_LO ##1 reg_rd && reg_addr == `LPR_ADDR_L1_HI);
    cv_irq: cover property (@(posedge clk) disable iff (!nrst) !int_oe_n);
    cv_valid: cover property (@(posedge clk) disable iff (!nrst) light_cycle_done && light_valid_clear);
endmodule
`default_nettype wire

/* lpr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpr_core_model (
    // Clock, reset and conversion request.
    input wire logic clk,
    input wire logic nrst,
    input wire logic step,
    // Results toward the register block.
    output logic done,
    output logic [15:0] first,
    output logic [15:0] second,
    output logic [15:0] prox
);
    // Each step is one finished conversion, and every high byte moves so a stale latch shows.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
            first <= 16'hA1B2;
            second <= 16'hC3D4;
            prox <= 16'hE5F6;
        end else begin
            done <= step;
            if (step) begin
                first <= first + 16'h0101;
                second <= second + 16'h0101;
                prox <= prox + 16'h0101;
            end
        end
    end
endmodule
`default_nettype wire

/* light_prox_result_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpr_params.svh"
module light_prox_result_regs_tb;
    import lpr_pkg::*;
    logic clk, nrst, reg_wr, reg_rd, step, vclr, pirq, lirq, done, src, int_o, int_oe_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a;
    logic [15:0] first, second, prox, snap;
    lpr_drive_t drv;
    lpr_diode_t dio;
    lpr_gain_t gain;
    int n_errors = 0;
    int tests_run = 0;
    lpr_core_model core (.clk(clk), .nrst(nrst), .step(step), .done(done), .first(first),
        .second(second), .prox(prox));
    light_prox_result_regs DUT (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .light_cycle_done(done),
        .light_first_result(first), .light_second_result(second), .prox_result(prox),
        .prox_irq_flag(pirq), .light_irq_flag(lirq), .light_valid_clear(vclr), .led_drive_level(drv),
        .prox_diode_select(dio), .light_gain_select(gain), .light_irq_source_first(src),
        .int_o(int_o), .int_oe_n(int_oe_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask
    task automatic pulse_step;
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
    endtask
    task automatic pin(input logic e);
        repeat (4) @(posedge clk);
        #1;
        chk("int_oe_n", {7'h0, e}, {7'h0, int_oe_n});
        chk("int_o", 8'h00, {7'h0, int_o});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        {nrst, reg_wr, reg_rd, step, vclr, pirq, lirq} = 7'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rchk("ctrl", `LPR_ADDR_CTRL, `LPR_CTRL_RST);
        rchk("id", `LPR_ADDR_ID, `LPR_ID_VALUE);
        rchk("status", `LPR_ADDR_STAT, 8'h00);
        pin(1'b1);
        chk("source", 8'h01, {7'h0, src});
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], (i == 0) ? 2'h1 : i[1:0], 2'h0, ~i[1:0]};
            wr(`LPR_ADDR_CTRL, d);
            rchk("ctrl", `LPR_ADDR_CTRL, d);
            chk("drive", {6'h0, d[7:6]}, {6'h0, drv});
            chk("diode", {6'h0, d[5:4]}, {6'h0, dio});
            chk("gain", {6'h0, d[1:0]}, {6'h0, gain});
        end
        wr(`LPR_ADDR_ID, 8'hFF);
        rchk("id", `LPR_ADDR_ID, `LPR_ID_VALUE);
        wr(`LPR_ADDR_STAT, 8'hFF);
        rchk("status", `LPR_ADDR_STAT, 8'h00);
        wr(8'h40, 8'h77);
        rchk("unmapped", 8'h40, 8'h00);
        rchk("ctrl", `LPR_ADDR_CTRL, 8'hF0);
        pulse_step();
        rchk("status", `LPR_ADDR_STAT, 8'h01);
        @(posedge clk);
        vclr <= 1'b1;
        @(posedge clk);
        vclr <= 1'b0;
        rchk("status", `LPR_ADDR_STAT, 8'h00);
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        vclr <= 1'b1;
        @(posedge clk);
        vclr <= 1'b0;
        rchk("status", `LPR_ADDR_STAT, 8'h01);
        pirq <= 1'b1;
        pin(1'b0);
        rchk("status", `LPR_ADDR_STAT, 8'h21);
        pirq <= 1'b0;
        lirq <= 1'b1;
        pin(1'b0);
        rchk("status", `LPR_ADDR_STAT, 8'h11);
        lirq <= 1'b0;
        pin(1'b1);
        for (int k = 0; k < 3; k++) begin
            a = 8'h14 + 8'(2 * k);
            snap = (k == 0) ? first : (k == 1) ? second : prox;
            rchk("low", a, snap[7:0]);
            pulse_step();
            pulse_step();
            rchk("high", a + 8'h01, snap[15:8]);
        end
        // A second reset must bring back the control default and empty shadows.
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("rdata_rst", 8'h00, reg_rdata);
        nrst <= 1'b1;
        rchk("ctrl", `LPR_ADDR_CTRL, `LPR_CTRL_RST);
        rchk("high", `LPR_ADDR_PX_HI, 8'h00);
        rchk("status", `LPR_ADDR_STAT, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
